// >>> rtl/refsel_ctrl.sv
// Reference input selection and failover timing with its APB registers.
`timescale 1ns/100ps
module refsel_ctrl (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [4:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        vcxo_pulse,
  input  wire logic [1:0]  los_event,
  input  wire logic [1:0]  period_ok,
  input  wire logic [1:0]  period_missing,
  output logic             ref_mux_sel,
  output logic      [1:0]  los_flag,
  output logic             holdoff_running,
  output logic             irq
);
  typedef enum logic [1:0] {
    ST_TRACK   = 2'b00,
    ST_HOLDOFF = 2'b01
  } hold_state_t;

  refsel_pkg::ctrl_t        ctrl_reg, ctrl_next;
  refsel_pkg::holdoff_cfg_t hcfg_reg, hcfg_next;
  logic [refsel_pkg::IRQ_W-1:0] stat_reg, stat_next;
  logic [refsel_pkg::IRQ_W-1:0] mask_reg, mask_next;
  logic [31:0]              rdata_reg, rdata_next;
  logic                     err_reg, err_next;
  hold_state_t              state_reg, state_next;
  logic                     active_reg, active_next;

  logic                     setup;
  logic                     access;
  logic                     wr_ctrl;
  logic                     wr_hcfg;
  logic                     wr_mask;
  logic                     rd_stat;
  logic                     mapped;
  logic [1:0]               lost;
  logic [1:0]               revalidated;
  logic                     expire;
  logic                     failover;
  logic                     sel_bit;
  logic                     mode_auto;
  logic                     mode_hold;
  refsel_pkg::ctrl_t        wctrl;
  logic [refsel_pkg::IRQ_W-1:0] events;

  // APB decode: zero wait states, answer in the access cycle.
  assign setup   = psel && !penable;
  assign access  = psel && penable;
  assign pready  = access;
  assign prdata  = rdata_reg;
  assign pslverr = access && err_reg;

  assign mapped = paddr == refsel_pkg::OFF_CTRL ||
                  paddr == refsel_pkg::OFF_HOLDOFF ||
                  paddr == refsel_pkg::OFF_STATUS ||
                  paddr == refsel_pkg::OFF_IRQ_STAT ||
                  paddr == refsel_pkg::OFF_IRQ_MASK;

  assign wr_ctrl = access && pwrite && paddr == refsel_pkg::OFF_CTRL;
  assign wr_hcfg = access && pwrite && paddr == refsel_pkg::OFF_HOLDOFF;
  assign wr_mask = access && pwrite && paddr == refsel_pkg::OFF_IRQ_MASK;
  assign rd_stat = access && !pwrite && paddr == refsel_pkg::OFF_IRQ_STAT;

  assign wctrl = refsel_pkg::ctrl_t'(pwdata[refsel_pkg::CTRL_W-1:0]);

  // Per-input re-validation channels.
  for (genvar i = 0; i < 2; i++) begin : g_chan
    revalid_chan u_chan (
      .pclk           (pclk),
      .presetn        (presetn),
      .los_event      (los_event[i]),
      .period_ok      (period_ok[i]),
      .period_missing (period_missing[i]),
      .revalid_count  (ctrl_reg.revalid_count),
      .revalid_prediv (ctrl_reg.revalid_prediv),
      .los_flag       (lost[i]),
      .revalidated    (revalidated[i])
    );
  end

  holdoff_timer u_timer (
    .pclk       (pclk),
    .presetn    (presetn),
    .vcxo_pulse (vcxo_pulse),
    .run        (state_reg == ST_HOLDOFF),
    .cfg        (hcfg_reg),
    .expire     (expire)
  );

  // Register file next values.
  always_comb begin
    ctrl_next  = ctrl_reg;
    hcfg_next  = hcfg_reg;
    mask_next  = mask_reg;
    rdata_next = rdata_reg;
    err_next   = err_reg;
    if (wr_ctrl) begin
      ctrl_next = wctrl;
    end
    if (wr_hcfg) begin
      hcfg_next = refsel_pkg::holdoff_cfg_t'(
        pwdata[refsel_pkg::HCFG_W-1:0]);
    end
    if (wr_mask) begin
      mask_next = pwdata[refsel_pkg::IRQ_W-1:0];
    end
    if (setup) begin
      err_next   = !mapped;
      rdata_next = 32'h0000_0000;
      if (!pwrite) begin
        case (paddr)
          refsel_pkg::OFF_CTRL: begin
            rdata_next = {25'h0, ctrl_reg};
          end
          refsel_pkg::OFF_HOLDOFF: begin
            rdata_next = {22'h0, hcfg_reg};
          end
          refsel_pkg::OFF_STATUS: begin
            rdata_next = {28'h0, state_reg == ST_HOLDOFF,
                          active_reg, lost};
          end
          refsel_pkg::OFF_IRQ_STAT: begin
            rdata_next = {27'h0, stat_reg};
          end
          refsel_pkg::OFF_IRQ_MASK: begin
            rdata_next = {27'h0, mask_reg};
          end
          default: begin
            rdata_next = 32'h0000_0000;
          end
        endcase
      end
    end
  end

  // Sticky events; a read clears only the bits it returned, and a new
  // event in the same cycle stays set.
  assign events = {failover, revalidated, los_event};

  always_comb begin
    stat_next = stat_reg;
    if (rd_stat) begin
      stat_next = stat_reg & ~rdata_reg[refsel_pkg::IRQ_W-1:0];
    end
    stat_next = stat_next | events;
  end

  // Reference selection and holdover sequencing.
  assign sel_bit   = ctrl_reg.ref_select[0];
  assign mode_auto = ctrl_reg.select_mode[0];
  assign mode_hold = ctrl_reg.select_mode[1];

  always_comb begin
    active_next = active_reg;
    state_next  = state_reg;
    failover    = 1'b0;
    if (wr_ctrl) begin
      state_next = ST_TRACK;
      if (!wctrl.select_mode[0]) begin
        active_next = wctrl.ref_select[0];
      end
    end else begin
      case (refsel_pkg::select_mode_t'(ctrl_reg.select_mode))
        refsel_pkg::MODE_MANUAL: begin
          state_next  = ST_TRACK;
          active_next = sel_bit;
        end
        refsel_pkg::MODE_AUTO: begin
          state_next = ST_TRACK;
          if (lost[active_reg] && !lost[!active_reg]) begin
            active_next = !active_reg;
            failover    = 1'b1;
          end
        end
        default: begin
          case (state_reg)
            ST_TRACK: begin
              if (lost[active_reg]) begin
                state_next = ST_HOLDOFF;
              end
            end
            ST_HOLDOFF: begin
              if (expire) begin
                active_next = !active_reg;
                failover    = 1'b1;
                state_next  = ST_TRACK;
              end else if (!lost[active_reg]) begin
                state_next = ST_TRACK;
              end
            end
            default: begin
              state_next = ST_TRACK;
            end
          endcase
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg   <= refsel_pkg::CTRL_RESET;
      hcfg_reg   <= refsel_pkg::HCFG_RESET;
      stat_reg   <= '0;
      mask_reg   <= '0;
      rdata_reg  <= 32'h0000_0000;
      err_reg    <= 1'b0;
      state_reg  <= ST_TRACK;
      active_reg <= 1'b0;
    end else begin
      ctrl_reg   <= ctrl_next;
      hcfg_reg   <= hcfg_next;
      stat_reg   <= stat_next;
      mask_reg   <= mask_next;
      rdata_reg  <= rdata_next;
      err_reg    <= err_next;
      state_reg  <= state_next;
      active_reg <= active_next;
    end
  end

  assign ref_mux_sel     = active_reg;
  assign los_flag        = lost;
  assign holdoff_running = state_reg == ST_HOLDOFF;
  assign irq             = |(stat_reg & mask_reg);

  manual_select_a: assert property (@(posedge pclk)
    disable iff (!presetn)
    (ctrl_reg.select_mode == refsel_pkg::MODE_MANUAL && !wr_ctrl) |=>
      ref_mux_sel == $past(ctrl_reg.ref_select[0]))
    else $error("Manual mode did not follow ref_select.");

  auto_ignores_sel_a: assert property (@(posedge pclk)
    disable iff (!presetn)
    (mode_auto && !wr_ctrl && !lost[active_reg]) |=> $stable(ref_mux_sel))
    else $error("Automatic mode changed input without a loss.");

  holdoff_start_a: assert property (@(posedge pclk)
    disable iff (!presetn)
    (mode_hold && state_reg == ST_TRACK && lost[active_reg] && !wr_ctrl)
      |=> holdoff_running)
    else $error("Hold-off did not start on loss of the active input.");

  failover_switch_a: assert property (@(posedge pclk)
    disable iff (!presetn)
    (state_reg == ST_HOLDOFF && expire && !wr_ctrl) |=>
      ref_mux_sel != $past(ref_mux_sel) && stat_reg[refsel_pkg::IRQ_FAILOVER])
    else $error("Hold-off expiry did not switch the reference.");

  los_sticky_a: assert property (@(posedge pclk) disable iff (!presetn)
    los_event[0] |=> stat_reg[refsel_pkg::IRQ_LOS0] ##1 los_flag[0])
    else $error("Loss event was not recorded.");
endmodule

// >>> rtl/refsel_pkg.sv
// Shared constants, types and helpers for the reference selection block.
package refsel_pkg;

  // Register byte offsets on the APB slave.
  localparam logic [4:0] OFF_CTRL     = 5'h00;
  localparam logic [4:0] OFF_HOLDOFF  = 5'h04;
  localparam logic [4:0] OFF_STATUS   = 5'h08;
  localparam logic [4:0] OFF_IRQ_STAT = 5'h0c;
  localparam logic [4:0] OFF_IRQ_MASK = 5'h10;

  typedef enum logic [1:0] {
    MODE_MANUAL    = 2'b00,
    MODE_AUTO      = 2'b01,
    MODE_HOLDOVER  = 2'b10,
    MODE_AUTO_HOLD = 2'b11
  } select_mode_t;

  typedef struct packed {
    logic       revalid_prediv;
    logic [1:0] revalid_count;
    logic [1:0] ref_select;
    logic [1:0] select_mode;
  } ctrl_t;

  typedef struct packed {
    logic [1:0] holdoff_rate_div;
    logic [7:0] holdoff_count;
  } holdoff_cfg_t;

  localparam int CTRL_W    = 7;
  localparam int HCFG_W    = 10;
  localparam int IRQ_W     = 5;
  localparam int STATUS_W  = 4;
  localparam int REVAL_W   = 7;
  localparam int DIV_W     = 17;
  localparam int DIV_EXP0  = 15;

  localparam ctrl_t CTRL_RESET = '{revalid_prediv: 1'b0,
                                   revalid_count:  2'h2,
                                   ref_select:     2'h0,
                                   select_mode:    2'h0};
  localparam holdoff_cfg_t HCFG_RESET = '{holdoff_rate_div: 2'h2,
                                          holdoff_count:    8'h80};

  // Interrupt status bit positions.
  localparam int IRQ_LOS0     = 0;
  localparam int IRQ_REVAL0   = 2;
  localparam int IRQ_FAILOVER = 4;

  localparam logic [1:0] PREDIV_LAST = 2'h3;

  // Valid periods (after the prescaler) needed to re-validate an input.
  function automatic logic [REVAL_W-1:0] revalid_periods(
      input logic [1:0] code);
    case (code)
      2'h0:    revalid_periods = 7'h02;
      2'h1:    revalid_periods = 7'h10;
      2'h2:    revalid_periods = 7'h20;
      default: revalid_periods = 7'h40;
    endcase
  endfunction

  // Last VCXO pulse count of one hold-off tick: 2^(15+rate) - 1, with rate 3 giving 2^17 - 1 as rate 2 does.
  function automatic logic [DIV_W-1:0] div_terminal(
      input logic [1:0] rate);
    case (rate)
      2'h0:    div_terminal = 17'h07fff;
      2'h1:    div_terminal = 17'h0ffff;
      default: div_terminal = 17'h1ffff;
    endcase
  endfunction

endpackage

// >>> rtl/revalid_chan.sv
// Re-validation counter and loss-of-signal flag for one reference input.
`timescale 1ns/100ps
module revalid_chan (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       los_event,
  input  wire logic       period_ok,
  input  wire logic       period_missing,
  input  wire logic [1:0] revalid_count,
  input  wire logic       revalid_prediv,
  output logic            los_flag,
  output logic            revalidated
);
  logic [refsel_pkg::REVAL_W-1:0] cnt_reg, cnt_next;
  logic [1:0]                     pre_reg, pre_next;
  logic                           flag_reg, flag_next;
  logic                           done_reg, done_next;

  always_comb begin
    cnt_next  = cnt_reg;
    pre_next  = pre_reg;
    flag_next = flag_reg;
    done_next = 1'b0;
    if (los_event) begin
      flag_next = 1'b1;
      cnt_next  = refsel_pkg::revalid_periods(revalid_count);
      pre_next  = 2'h0;
    end else if (flag_reg) begin
      if (period_missing) begin
        cnt_next = refsel_pkg::revalid_periods(revalid_count);
        pre_next = 2'h0;
      end else if (period_ok) begin
        if (revalid_prediv && pre_reg != refsel_pkg::PREDIV_LAST) begin
          pre_next = pre_reg + 2'h1;
        end else begin
          pre_next = 2'h0;
          cnt_next = cnt_reg - 7'h01;
          if (cnt_reg <= 7'h01) begin
            cnt_next  = 7'h00;
            flag_next = 1'b0;
            done_next = 1'b1;
          end
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg  <= 7'h00;
      pre_reg  <= 2'h0;
      flag_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      cnt_reg  <= cnt_next;
      pre_reg  <= pre_next;
      flag_reg <= flag_next;
      done_reg <= done_next;
    end
  end

  assign los_flag    = flag_reg;
  assign revalidated = done_reg;

  los_load_a: assert property (@(posedge pclk) disable iff (!presetn)
    los_event |=> flag_reg &&
      cnt_reg == refsel_pkg::revalid_periods($past(revalid_count)))
    else $error("Loss event did not load the re-validation counter.");

  missing_restart_a: assert property (@(posedge pclk)
    disable iff (!presetn)
    (flag_reg && !los_event && period_missing) |=>
      cnt_reg == refsel_pkg::revalid_periods($past(revalid_count)))
    else $error("Missing period did not restart re-validation.");

  flag_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(flag_reg) |-> done_reg && cnt_reg == 7'h00)
    else $error("Flag cleared without counter reaching zero.");
endmodule

// >>> rtl/holdoff_timer.sv
// Hold-off tick divider and hold-off down counter.
`timescale 1ns/100ps
module holdoff_timer (
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  input  wire logic                     vcxo_pulse,
  input  wire logic                     run,
  input  wire refsel_pkg::holdoff_cfg_t cfg,
  output logic                          expire
);
  logic [refsel_pkg::DIV_W-1:0] div_reg, div_next;
  logic [7:0]                   cnt_reg, cnt_next;
  logic                         exp_reg, exp_next;
  logic                         tick;

  // A tick is the last VCXO pulse of one divided period.
  assign tick = vcxo_pulse &&
    div_reg == refsel_pkg::div_terminal(cfg.holdoff_rate_div);

  always_comb begin
    div_next = div_reg;
    cnt_next = cnt_reg;
    exp_next = 1'b0;
    if (!run) begin
      div_next = '0;
      cnt_next = cfg.holdoff_count;
    end else if (vcxo_pulse) begin
      div_next = tick ? '0 : div_reg + 17'h00001;
      if (tick) begin
        cnt_next = cnt_reg - 8'h01;
        if (cnt_reg <= 8'h01) begin
          exp_next = 1'b1;
          cnt_next = cfg.holdoff_count;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_reg <= '0;
      cnt_reg <= refsel_pkg::HCFG_RESET.holdoff_count;
      exp_reg <= 1'b0;
    end else begin
      div_reg <= div_next;
      cnt_reg <= cnt_next;
      exp_reg <= exp_next;
    end
  end

  assign expire = exp_reg;

  tick_rate_a: assert property (@(posedge pclk) disable iff (!presetn)
    (run && vcxo_pulse && !tick) |=> div_reg == $past(div_reg) + 17'h1)
    else $error("Hold-off divider did not advance on a VCXO pulse.");

  reload_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    exp_reg |-> cnt_reg == $past(cfg.holdoff_count) &&
      $past(cnt_reg) <= 8'h01 && $past(tick))
    else $error("Hold-off counter did not reload at its zero transition.");
endmodule

// >>> verif/ref_source_model.sv
// Behavioural model of the two reference sources and the VCXO strobe.
`timescale 1ns/100ps
module ref_source_model (
  input  wire logic       pclk,
  output logic            vcxo_pulse,
  output logic [1:0]      los_event,
  output logic [1:0]      period_ok,
  output logic [1:0]      period_missing
);
  initial begin
    vcxo_pulse     = 1'b0;
    los_event      = 2'h0;
    period_ok      = 2'h0;
    period_missing = 2'h0;
  end

  // The VCXO runs free once started, one strobe per clock.
  task automatic vcxo(input logic on);
    @(posedge pclk) vcxo_pulse <= on;
  endtask

  task automatic lose(input logic [1:0] m);
    @(posedge pclk) los_event <= m;
    @(posedge pclk) los_event <= 2'h0;
  endtask

  task automatic periods(input logic [1:0] m, input int n);
    repeat (n) begin
      @(posedge pclk) period_ok <= m;
      @(posedge pclk) period_ok <= 2'h0;
    end
  endtask

  task automatic miss(input logic [1:0] m);
    @(posedge pclk) period_missing <= m;
    @(posedge pclk) period_missing <= 2'h0;
  endtask
endmodule

// >>> verif/test_refsel_ctrl.sv
// Self-checking testbench for the reference selection block.
`timescale 1ns/100ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin \
  fail_count++; $display("Error %s expected %h seen %h", n, e, g); end end
module test_refsel_ctrl;
  logic        pclk;
  logic        presetn;
  logic [4:0]  paddr;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        vcxo_pulse;
  logic [1:0]  los_event;
  logic [1:0]  period_ok;
  logic [1:0]  period_missing;
  logic        ref_mux_sel;
  logic [1:0]  los_flag;
  logic        holdoff_running;
  logic        irq;
  int          fail_count;
  int          comparisons;
  int          need[8] = '{2, 16, 32, 64, 8, 64, 128, 256};
  logic [31:0] q;
  logic        e;
  int          k;

  refsel_ctrl dut (
    .pclk            (pclk),
    .presetn         (presetn),
    .paddr           (paddr),
    .psel            (psel),
    .penable         (penable),
    .pwrite          (pwrite),
    .pwdata          (pwdata),
    .prdata          (prdata),
    .pready          (pready),
    .pslverr         (pslverr),
    .vcxo_pulse      (vcxo_pulse),
    .los_event       (los_event),
    .period_ok       (period_ok),
    .period_missing  (period_missing),
    .ref_mux_sel     (ref_mux_sel),
    .los_flag        (los_flag),
    .holdoff_running (holdoff_running),
    .irq             (irq)
  );

  ref_source_model src (
    .pclk           (pclk),
    .vcxo_pulse     (vcxo_pulse),
    .los_event      (los_event),
    .period_ok      (period_ok),
    .period_missing (period_missing)
  );

  initial pclk = 1'b0;
  always #12.5 pclk = ~pclk;

  task automatic apb(input logic [4:0] a, input logic w,
                     input logic [31:0] d);
    @(posedge pclk);
    paddr   <= a;
    pwrite  <= w;
    pwdata  <= d;
    psel    <= 1'b1;
    penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [4:0] a, input logic [31:0] x);
    apb(a, 1'b0, 32'h0);
    `CHK("read data", x, q)
  endtask

  task automatic settle(input int n);
    repeat (n) @(negedge pclk);
  endtask

  task automatic end_of_test;
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge pclk);
    fail_count++;
    $display("Error watchdog expired");
    end_of_test;
  end

  initial begin
    presetn = 1'b0;
    paddr   = 5'h00;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    pwdata  = 32'h0;
    fail_count  = 0;
    comparisons = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rd(refsel_pkg::OFF_CTRL, 32'h20);
    rd(refsel_pkg::OFF_HOLDOFF, 32'h280);
    rd(refsel_pkg::OFF_STATUS, 32'h0);
    rd(refsel_pkg::OFF_IRQ_MASK, 32'h0);
    rd(5'h14, 32'h0);
    `CHK("unmapped error", 1'b1, e)
    // Automatic mode with ref_select pointing at input 1.
    apb(refsel_pkg::OFF_CTRL, 1'b1, 32'h05);
    settle(1);
    `CHK("auto mux", 1'b0, ref_mux_sel)
    src.lose(2'h1);
    settle(2);
    `CHK("auto failover", 1'b1, ref_mux_sel)
    src.periods(2'h1, 2);
    settle(1);
    `CHK("auto revalid", 2'h0, los_flag)
    apb(refsel_pkg::OFF_CTRL, 1'b1, 32'h04);
    settle(1);
    `CHK("manual sel 1", 1'b1, ref_mux_sel)
    apb(refsel_pkg::OFF_CTRL, 1'b1, 32'h00);
    settle(1);
    `CHK("manual sel 0", 1'b0, ref_mux_sel)
    apb(refsel_pkg::OFF_IRQ_STAT, 1'b0, 32'h0);
    for (k = 0; k < 8; k++) begin
      apb(refsel_pkg::OFF_CTRL, 1'b1, 32'((k / 4) << 6 | (k % 4) << 4));
      src.lose(2'h1);
      src.periods(2'h1, need[k] - 1);
      settle(1);
      `CHK("flag before last", 2'h1, los_flag)
      src.periods(2'h1, 1);
      settle(1);
      `CHK("flag after last", 2'h0, los_flag)
      rd(refsel_pkg::OFF_IRQ_STAT, 32'h05);
    end
    apb(refsel_pkg::OFF_CTRL, 1'b1, 32'h00);
    src.lose(2'h1);
    src.periods(2'h1, 1);
    src.miss(2'h1);
    src.periods(2'h1, 1);
    settle(1);
    `CHK("restart after miss", 2'h1, los_flag)
    src.periods(2'h1, 1);
    settle(1);
    `CHK("revalid after miss", 2'h0, los_flag)
    src.lose(2'h3);
    src.periods(2'h1, 1);
    src.periods(2'h3, 1);
    settle(1);
    `CHK("independent flags", 2'h2, los_flag)
    src.periods(2'h2, 1);
    settle(1);
    `CHK("both revalid", 2'h0, los_flag)
    // Short-term holdover, one tick of 2^15 strobes.
    apb(refsel_pkg::OFF_HOLDOFF, 1'b1, 32'h001);
    rd(refsel_pkg::OFF_HOLDOFF, 32'h001);
    // Automatic with holdover: re-validation ends the hold-off early.
    apb(refsel_pkg::OFF_CTRL, 1'b1, 32'h03);
    src.lose(2'h1);
    settle(2);
    `CHK("auto hold start", 1'b1, holdoff_running)
    src.periods(2'h1, 2);
    settle(2);
    `CHK("auto hold stop", 1'b0, holdoff_running)
    `CHK("auto hold keep", 1'b0, ref_mux_sel)
    apb(refsel_pkg::OFF_CTRL, 1'b1, 32'h02);
    apb(refsel_pkg::OFF_IRQ_STAT, 1'b0, 32'h0);
    apb(refsel_pkg::OFF_IRQ_MASK, 1'b1, 32'h10);
    rd(refsel_pkg::OFF_IRQ_MASK, 32'h10);
    src.vcxo(1'b1);
    src.lose(2'h1);
    settle(2);
    `CHK("holdoff started", 1'b1, holdoff_running)
    `CHK("irq masked", 1'b0, irq)
    rd(refsel_pkg::OFF_STATUS, 32'h9);
    repeat (32700) @(posedge pclk);
    settle(1);
    `CHK("no early switch", 1'b0, ref_mux_sel)
    k = 0;
    while (ref_mux_sel !== 1'b1 && k < 300) begin
      settle(1);
      k++;
    end
    `CHK("holdoff failover", 1'b1, ref_mux_sel)
    `CHK("holdoff stopped", 1'b0, holdoff_running)
    `CHK("irq raised", 1'b1, irq)
    rd(refsel_pkg::OFF_IRQ_STAT, 32'h11);
    settle(1);
    `CHK("irq cleared", 1'b0, irq)
    end_of_test;
  end
endmodule
